// file: rtl/swmon_spi_pkg.sv
// Shared constants, types and decode functions of the switch-monitor serial port
package swmon_spi_pkg;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int          FRAME_BITS    = 32;
	localparam int          ADDR_W        = 6;
	localparam int          DATA_W        = 24;
	localparam int          CNT_W         = 6;
	localparam int          RW_BIT        = 31;
	localparam int          ADDR_HI       = 30;
	localparam int          ADDR_LO       = 25;
	localparam int          DATA_HI       = 24;
	localparam int          DATA_LO       = 1;
	localparam logic [5:0]  LEN_OK        = 6'h20;
	localparam logic [5:0]  CNT_MAX       = 6'h3F;
	localparam logic [5:0]  ADDR_LAST_CNT = 6'h06;
	localparam logic [4:0]  TX_FIRST      = 5'h1F;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [5:0]  STAT_ADDR     = 6'h02;
	localparam logic [5:0]  RO_LO         = 6'h01;
	localparam logic [5:0]  RO_HI         = 6'h05;
	localparam logic [5:0]  RW_LO         = 6'h1A;
	localparam logic [5:0]  RW_HI         = 6'h24;
	localparam logic [5:0]  TEST_LO       = 6'h33;
	localparam logic [5:0]  TEST_HI       = 6'h3F;

	// ----------------------------------------------------------------
	// Interrupt status bits
	// ----------------------------------------------------------------
	localparam int          ST_POR        = 0;
	localparam int          ST_SPI_FAIL   = 1;
	localparam int          ST_PRTY       = 2;
	localparam int          ST_SSC        = 3;
	localparam int          ST_TW         = 4;
	localparam int          ST_TSD        = 5;
	localparam int          ST_OV         = 6;
	localparam int          ST_UV         = 7;
	localparam int          ST_CRC        = 8;
	localparam int          ST_CHK        = 13;
	localparam logic [23:0] STAT_RESET    = 24'h000001;
	localparam logic [23:0] STAT_CLEAR    = 24'h000000;
	localparam int          FL_RES        = 27;

	typedef enum logic [2:0] {KIND_NONE, KIND_RO, KIND_STAT, KIND_RW, KIND_TEST} kind_t;

	typedef struct packed {
		logic switch_change;
		logic thermal_warning;
		logic thermal_shutdown;
		logic over_voltage;
		logic under_voltage;
		logic checksum_done;
		logic config_check_failure;
	} events_t;

	typedef struct packed {
		logic por;
		logic spi_fail;
		logic parity_error_flag;
		logic switch_change_flag;
		logic reserved_flag;
		logic temp;
		logic other_event_flag;
	} flags_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} wr_t;

	function automatic kind_t addr_kind(input logic [5:0] a);
		if (a == STAT_ADDR) begin
			return KIND_STAT;
		end else if (a >= RO_LO && a <= RO_HI) begin
			return KIND_RO;
		end else if (a >= RW_LO && a <= RW_HI) begin
			return KIND_RW;
		end else if (a >= TEST_LO && a <= TEST_HI) begin
			return KIND_TEST;
		end else begin
			return KIND_NONE;
		end
	endfunction : addr_kind

	function automatic flags_t flags_of(input logic [23:0] s);
		flags_t f;
		f.por                = s[ST_POR];
		f.spi_fail           = s[ST_SPI_FAIL];
		f.parity_error_flag  = s[ST_PRTY];
		f.switch_change_flag = s[ST_SSC];
		f.reserved_flag      = 1'b0;
		f.temp               = s[ST_TW] | s[ST_TSD];
		f.other_event_flag   = s[ST_OV] | s[ST_UV] | s[ST_CRC] | s[ST_CHK];
		return f;
	endfunction : flags_of

endpackage : swmon_spi_pkg

// file: rtl/cfg_store.sv
// Register storage: written on the core clock, read into a register on the serial clock
`timescale 1ns/10ps
module cfg_store #(
	parameter int AW = 6,
	parameter int DW = 24
) (
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          rclk,
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	// Writes only happen between frames, so the serial-side read never races them
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < 2**AW; i++) begin
				mem[i] <= '0;
			end
		end else if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(negedge rclk) begin
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule : cfg_store

// file: rtl/swmon_spi.sv
// Serial frame engine of the switch monitor: shifting, write commit and status flags
`timescale 1ns/10ps

// How it works
// - Write frames return status flags first, then the register's previous contents.
// - Old contents are latched once address bit 25 has been shifted in.
// - Write commits at frame end only with valid address, length and parity.
// - Any invalid write frame is dropped; the register stays unchanged.
// - The final output bit is a parity bit over the outgoing word.
// - Writes to test registers are ignored, but their contents are returned.
// - Writes to nonexistent addresses return all-zero data bits.
// - Every frame carries status flags mirrored from interrupt status.
// - Reading interrupt status clears it and the flags at chip-select rise.
// - The reset-event flag is set after every reset.
// - Frames must be exactly 32 bits; otherwise flag length error, drive interrupt low.
// - No length error when chip select pulses without any serial clock.
// - Odd parity; an even count discards the frame and sets parity error.
// - Switch-change flag sets when any switch crosses its threshold.
// - The reserved flag always reads zero.
// - Thermal flag follows warning or shutdown bits, set on entry and exit.
// - Other-event flag ORs over-voltage, under-voltage, checksum and config-check bits.
// - Input sampled on falling, output changed on rising clock; MSB first.
// - Chip-select fall enables output and freezes the status snapshot.
// - Chip-select rise floats output and releases interrupt after status read.
module swmon_spi
	import swmon_spi_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    srst,
	input  wire logic    sclk,
	input  wire logic    cs_n,
	input  wire logic    si,
	input  wire events_t events,
	output logic         so,
	output logic         so_oe,
	output logic         int_n,
	output wr_t          wr
);

	// ----------------------------------------------------------------
	// Link side: receive on falling serial clock
	// ----------------------------------------------------------------
	logic              rx_armed;
	logic [31:0]       rx_word;
	logic [CNT_W-1:0]  rx_count;
	logic              edge_tog;
	logic [ADDR_W-1:0] old_addr;
	logic              rd_old;
	logic [DATA_W-1:0] mem_q;

	// Raised while chip select is high, dropped by the frame's first clock;
	// the link has no clock during reset, so reset reaches it by level
	always_ff @(negedge sclk or posedge cs_n or posedge srst) begin
		if (cs_n || srst) begin
			rx_armed <= 1'b1;
		end else begin
			rx_armed <= 1'b0;
		end
	end

	always_ff @(negedge sclk) begin
		if (rx_armed) begin
			rx_word  <= {31'h0, si};
			rx_count <= 6'h01;
		end else begin
			rx_word  <= {rx_word[30:0], si};
			rx_count <= (rx_count == CNT_MAX) ? CNT_MAX : rx_count + 6'h01;
		end
	end

	// Toggles once per clocked frame; the core side compares it to spot frames without a clock
	always_ff @(negedge sclk or posedge srst) begin
		if (srst) begin
			edge_tog <= 1'b0;
		end else if (rx_armed) begin
			edge_tog <= ~edge_tog;
		end
	end

	// Seventh falling edge: the RW bit and five address bits are in and the last address bit is on si
	assign rd_old = !rx_armed && rx_count == ADDR_LAST_CNT;

	always_ff @(negedge sclk) begin
		if (rd_old) begin
			old_addr <= {rx_word[4:0], si};
		end
	end

	// ----------------------------------------------------------------
	// Link side: transmit on rising serial clock
	// ----------------------------------------------------------------
	logic [23:0] frame_stat;
	flags_t      frame_flags;
	logic [23:0] old_data;
	logic [31:0] out_word;
	logic        tx_armed;
	logic [4:0]  tx_idx;
	logic [4:0]  tx_cur;

	always_comb begin
		frame_flags = flags_of(frame_stat);
		case (addr_kind(old_addr))
			KIND_STAT: old_data = frame_stat;
			KIND_NONE: old_data = '0;
			default:   old_data = mem_q;
		endcase
		out_word = {frame_flags, old_data, ~^{frame_flags, old_data}};
	end

	always_ff @(posedge sclk or posedge cs_n or posedge srst) begin
		if (cs_n || srst) begin
			tx_armed <= 1'b1;
		end else begin
			tx_armed <= 1'b0;
		end
	end

	assign tx_cur = tx_armed ? TX_FIRST : tx_idx;

	always_ff @(posedge sclk) begin
		tx_idx <= tx_cur - 5'h01;
	end

	// Idles high; the first rising clock of a frame shows bit 31
	always_ff @(posedge sclk or posedge cs_n or posedge srst) begin
		if (cs_n || srst) begin
			so <= 1'b1;
		end else begin
			so <= out_word[tx_cur];
		end
	end

	// Commit path, worked out by the frame checks further down
	logic [ADDR_W-1:0] rx_addr;
	logic [DATA_W-1:0] rx_data;
	logic              do_write;

	cfg_store #(
		.AW(ADDR_W),
		.DW(DATA_W)
	) u_store (
		.clk  (clk),
		.srst (srst),
		.we   (do_write),
		.waddr(rx_addr),
		.wdata(rx_data),
		.rclk (sclk),
		.re   (rd_old),
		.raddr({rx_word[4:0], si}),
		.rdata(mem_q)
	);

	// ----------------------------------------------------------------
	// Core side: chip select and frame activity crossing
	// ----------------------------------------------------------------
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic tog_meta;
	logic tog_sync;
	logic tog_seen;

	always_ff @(posedge clk) begin
		if (srst) begin
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_prev  <= 1'b1;
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
		end else begin
			cs_meta  <= cs_n;
			cs_sync  <= cs_meta;
			cs_prev  <= cs_sync;
			tog_meta <= edge_tog;
			tog_sync <= tog_meta;
		end
	end

	// ----------------------------------------------------------------
	// Core side: frame checks at chip-select rise
	// ----------------------------------------------------------------
	logic              frame_end;
	logic              had_edges;
	logic              len_err;
	logic              par_err;
	logic              frame_ok;
	logic              is_write;
	logic              stat_clear;

	// The receive word is stable here: no serial clock runs while chip select is high
	always_comb begin
		frame_end  = cs_sync && !cs_prev;
		had_edges  = tog_sync != tog_seen;
		len_err    = had_edges && rx_count != LEN_OK;
		par_err    = had_edges && !len_err && !(^rx_word);
		frame_ok   = had_edges && !len_err && !par_err;
		is_write   = rx_word[RW_BIT];
		rx_addr    = rx_word[ADDR_HI:ADDR_LO];
		rx_data    = rx_word[DATA_HI:DATA_LO];
		do_write   = frame_end && frame_ok && is_write && addr_kind(rx_addr) == KIND_RW;
		stat_clear = frame_end && frame_ok && !is_write && addr_kind(rx_addr) == KIND_STAT;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			tog_seen <= 1'b0;
		end else if (frame_end) begin
			tog_seen <= tog_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr <= '0;
		end else begin
			wr.valid <= do_write;
			wr.addr  <= rx_addr;
			wr.data  <= rx_data;
		end
	end

	// ----------------------------------------------------------------
	// Core side: interrupt status
	// ----------------------------------------------------------------
	logic        tw_prev;
	logic        tsd_prev;
	logic [23:0] set_bits;
	logic [23:0] int_stat;
	logic [23:0] next_stat;

	always_ff @(posedge clk) begin
		if (srst) begin
			tw_prev  <= 1'b0;
			tsd_prev <= 1'b0;
		end else begin
			tw_prev  <= events.thermal_warning;
			tsd_prev <= events.thermal_shutdown;
		end
	end

	always_comb begin
		set_bits              = '0;
		set_bits[ST_SPI_FAIL] = frame_end && len_err;
		set_bits[ST_PRTY]     = frame_end && par_err;
		set_bits[ST_SSC]      = events.switch_change;
		set_bits[ST_TW]       = events.thermal_warning != tw_prev;
		set_bits[ST_TSD]      = events.thermal_shutdown != tsd_prev;
		set_bits[ST_OV]       = events.over_voltage;
		set_bits[ST_UV]       = events.under_voltage;
		set_bits[ST_CRC]      = events.checksum_done;
		set_bits[ST_CHK]      = events.config_check_failure;
		// A new event in the clearing cycle survives the clear
		next_stat = (stat_clear ? STAT_CLEAR : int_stat) | set_bits;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			int_stat <= STAT_RESET;
			int_n    <= 1'b0;
		end else begin
			int_stat <= next_stat;
			int_n    <= ~|next_stat;
		end
	end

	// Snapshot tracks the live status between frames and freezes inside one
	always_ff @(posedge clk) begin
		if (srst) begin
			frame_stat <= STAT_RESET;
			so_oe      <= 1'b0;
		end else begin
			so_oe <= !cs_sync;
			if (cs_sync) begin
				frame_stat <= int_stat;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Frame length, parity and commit
	a_len_flag: assert property (frame_end && len_err |=> int_stat[ST_SPI_FAIL] && !int_n)
		else $error("length error not flagged");
	a_no_clk_quiet: assert property (frame_end && !had_edges |=> !wr.valid &&
		int_stat[ST_SPI_FAIL] == $past(int_stat[ST_SPI_FAIL]))
		else $error("frame without clock raised an error");
	a_par_flag: assert property (frame_end && par_err |=> int_stat[ST_PRTY] && !int_n)
		else $error("parity error not flagged");
	a_bad_no_write: assert property (frame_end && !frame_ok |=> !wr.valid)
		else $error("invalid frame was committed");
	a_write_kind: assert property (wr.valid |-> addr_kind(wr.addr) == KIND_RW)
		else $error("write reached a non-writable register");
	a_commit: assert property (do_write |=> wr.valid && wr.addr == $past(rx_addr) &&
		wr.data == $past(rx_data))
		else $error("committed word does not match the frame");
	a_valid_pulse: assert property (wr.valid |=> !wr.valid)
		else $error("commit strobe longer than one cycle");
	a_len_no_par: assert property (frame_end && len_err |=>
		int_stat[ST_PRTY] == $past(int_stat[ST_PRTY]))
		else $error("parity flagged on a frame of wrong length");

	// Status bits and the interrupt line
	a_read_clear: assert property (stat_clear && set_bits == '0 |=> int_stat == '0 && int_n)
		else $error("status read did not clear and release");
	a_int_level: assert property (##1 (int_n == (int_stat == '0)))
		else $error("interrupt output disagrees with status");
	a_keep_bits: assert property (!stat_clear |=>
		(int_stat & $past(int_stat)) == $past(int_stat))
		else $error("status bit dropped without a read");
	a_snap_frozen: assert property (!cs_sync && !$past(cs_sync) |-> $stable(frame_stat))
		else $error("status snapshot moved inside a frame");
	a_snap_track: assert property (cs_sync |=> frame_stat == $past(int_stat))
		else $error("status snapshot not tracking between frames");

	// Serial line and output enable
	a_oe_on: assert property ($fell(cs_sync) |=> so_oe)
		else $error("output enable did not follow chip select fall");
	a_oe_off: assert property ($rose(cs_sync) |=> !so_oe)
		else $error("output enable did not follow chip select rise");
	a_so_idle: assert property (cs_sync && cs_prev |-> so)
		else $error("serial output not idle high");
	a_res_zero: assert property (!out_word[FL_RES])
		else $error("reserved flag not zero");

	// Event capture
	a_temp_edge: assert property ($changed(events.thermal_warning) |=> int_stat[ST_TW])
		else $error("thermal change not recorded");
	a_tsd_edge: assert property ($changed(events.thermal_shutdown) |=> int_stat[ST_TSD])
		else $error("shutdown change not recorded");
	a_switch_set: assert property (events.switch_change |=> int_stat[ST_SSC] && !int_n)
		else $error("switch change not recorded");
	a_other_set: assert property (events.over_voltage || events.under_voltage ||
		events.checksum_done || events.config_check_failure |=>
		int_stat[ST_OV] || int_stat[ST_UV] || int_stat[ST_CRC] || int_stat[ST_CHK])
		else $error("other event not recorded");

	c_write: cover property (wr.valid);
	c_clear: cover property (stat_clear);
	c_len: cover property (frame_end && len_err);
	c_par: cover property (frame_end && par_err);
	c_quiet: cover property (frame_end && !had_edges);

endmodule : swmon_spi

// file: verif/spi_master_model.sv
// Serial master model that frames words into the switch monitor
`timescale 1ns/10ps
module spi_master_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	initial begin
		sclk = 1'h0;
		cs_n = 1'h1;
		si   = 1'h0;
	end

	// ----------------------------------------------------------------
	// Frame: n clocked bits of w, MSB first, answer collected
	// ----------------------------------------------------------------
	task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
		logic [63:0] t;
		t = {w, 32'h0};
		r = 32'h0;
		cs_n = 1'h0;
		#20;
		for (int k = 0; k < n; k++) begin
			#3 si = t[63];
			t = t << 1;
			#3 sclk = 1'h1;
			#6 r = {r[30:0], so};
			sclk = 1'h0;
		end
		// Line no longer qualified: show the inverse rather than a held value
		#3 si = ~si;
		#3 cs_n = 1'h1;
		#50;
	endtask : frame
endmodule : spi_master_model

// file: verif/tb_top.sv
// Self-checking bench of the switch monitor serial frame engine
`timescale 1ns/10ps
module tb_top;
	import swmon_spi_pkg::*;

	logic        clk;
	logic        srst;
	logic        sclk;
	logic        cs_n;
	logic        si;
	logic        so;
	logic        so_oe;
	logic        int_n;
	events_t     events;
	wr_t         wr;
	wr_t         wlast;
	int          err_total   = 0;
	int          comparisons = 0;
	int          wcnt        = 0;
	logic [31:0] r;
	int          oe_cnt      = 0;
	logic [23:0] mem [64];

	swmon_spi DUT (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si),
		.events(events), .so(so), .so_oe(so_oe), .int_n(int_n), .wr(wr));
	spi_master_model m (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (wr.valid === 1'h1) begin
			wcnt  <= wcnt + 1;
			wlast <= wr;
		end
	end

	always @(posedge clk) begin
		if (so_oe === 1'h1) begin
			oe_cnt <= oe_cnt + 1;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] mk(input logic w, input logic [5:0] a, input logic [23:0] d);
		logic [31:0] x;
		x    = {w, a, d, 1'h0};
		x[0] = ~^x;
		return x;
	endfunction : mk

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic xfer(input logic [31:0] w, input int n);
		m.frame(w, n, r);
		repeat (12) @(posedge clk);
	endtask : xfer

	task automatic rd_stat();
		xfer(mk(1'h0, STAT_ADDR, 24'h0), 32);
	endtask : rd_stat

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#200000;
		err_total++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int          w0;
		logic [5:0]  a;
		logic [23:0] d;
		srst   = 1'h0;
		events = 7'h00;
		void'($urandom(99918));
		for (int i = 0; i < 64; i++) begin
			mem[i] = 24'h0;
		end
		// A clean rising edge clears the link logic, which has no clock of its own yet
		#1 srst = 1'h1;
		repeat (6) @(posedge clk);
		@(negedge clk) srst = 1'h0;
		repeat (4) @(posedge clk);
		chk("int_n after reset", 32'h0, int_n);
		chk("so_oe idle", 32'h0, so_oe);
		rd_stat();
		chk("reset flag", 32'h1, r[31]);
		chk("status data", 32'h1, r[24:1]);
		chk("reserved flag", 32'h0, r[27]);
		chk("out parity", 32'h1, ^r);
		chk("int_n released", 32'h1, int_n);
		chk("so_oe in frame", 32'h1, 32'(oe_cnt > 0));
		chk("so_oe after frame", 32'h0, so_oe);
		rd_stat();
		chk("flags cleared", 32'h0, r[31:25]);
		$display("test status_read done");
		for (int i = 0; i < 5; i++) begin
			a  = 6'h1A + 6'($urandom_range(10));
			d  = 24'($urandom);
			w0 = wcnt;
			xfer(mk(1'h1, a, d), 32);
			chk("old data", mem[a], r[24:1]);
			chk("commit count", w0 + 1, wcnt);
			chk("commit word", {1'h1, a, d}, wlast);
			mem[a] = d;
		end
		$display("test writes done");
		w0 = wcnt;
		xfer(mk(1'h1, a, ~d) ^ 32'h1, 32);
		chk("no write on parity", w0, wcnt);
		chk("int_n on parity", 32'h0, int_n);
		xfer(mk(1'h0, a, 24'h0), 32);
		chk("parity flag", 32'h1, r[29]);
		chk("kept data", mem[a], r[24:1]);
		rd_stat();
		$display("test parity done");
		for (int n = 31; n <= 33; n += 2) begin
			w0 = wcnt;
			xfer(mk(1'h1, a, ~d), n);
			chk("no write on length", w0, wcnt);
			chk("int_n on length", 32'h0, int_n);
			rd_stat();
			chk("length flag", 32'h1, r[30]);
		end
		xfer(32'h0, 0);
		rd_stat();
		chk("no flag without clock", 32'h0, r[31:25]);
		$display("test length done");
		w0 = wcnt;
		xfer(mk(1'h1, 6'h33, d), 32);
		chk("test reg data", 32'h0, r[24:1]);
		xfer(mk(1'h1, 6'h10, d), 32);
		chk("invalid addr data", 32'h0, r[24:1]);
		chk("no write test or invalid", w0, wcnt);
		$display("test odd addresses done");
		@(negedge clk) events = 7'h40;
		@(negedge clk) events = 7'h08;
		@(negedge clk) events = 7'h20;
		repeat (4) @(posedge clk);
		chk("int_n on event", 32'h0, int_n);
		rd_stat();
		chk("switch flag", 32'h1, r[28]);
		chk("other flag", 32'h1, r[25]);
		chk("temp flag", 32'h1, r[26]);
		@(negedge clk) events = 7'h00;
		repeat (4) @(posedge clk);
		rd_stat();
		chk("temp on exit", 32'h1, r[26]);
		for (int b = 0; b < 3; b++) begin
			@(negedge clk) events = 7'(1 << b);
			@(negedge clk) events = 7'h00;
			rd_stat();
			chk("other flag source", 32'h1, r[25]);
		end
		$display("test events done");
		print_verdict();
	end
endmodule : tb_top
